// ### exd_defines.svh
// Constants for the exchange / exclusive-OR nibble datapath
`ifndef EXD_DEFINES_SVH
`define EXD_DEFINES_SVH
`define EXD_OP_SWAP      8'hC4
`define EXD_OP_EXCH_DIR  8'hC5
`define EXD_OP_EXCH_IND  7'h63
`define EXD_OP_EXCH_REG  5'h19
`define EXD_OP_DIGX_IND  7'h6B
`define EXD_OP_XOR_REG   5'h0D
`define EXD_OP_XOR_DIR   8'h65
`define EXD_OP_XOR_IND   7'h33
`define EXD_OP_XOR_IMM   8'h64
`define EXD_OP_XOR_DA    8'h62
`define EXD_OP_XOR_DI    8'h63
`define EXD_OP_ADC_REG   5'h07
`define EXD_OP_ADC_DIR   8'h35
`define EXD_OP_ADC_IND   7'h1B
`define EXD_OP_ADC_IMM   8'h34
`define EXD_OP_SBB_REG   5'h13
`define EXD_OP_SBB_DIR   8'h95
`define EXD_OP_SBB_IND   7'h4B
`define EXD_OP_SBB_IMM   8'h94
`define EXD_OP_DIV       8'h84
`define EXD_ACC_RST      8'h00
`define EXD_B_RST        8'h00
`define EXD_NIB_DIV      8'h10
`endif

// ### exd_pkg.sv
// Types for the exchange / exclusive-OR nibble datapath
package exd_pkg;
  typedef enum logic [1:0] {
    EXD_SEL_REG = 2'h0,
    EXD_SEL_DIR = 2'h1,
    EXD_SEL_IND = 2'h3,
    EXD_SEL_IMM = 2'h2
  } exd_src_e;
  typedef enum logic [1:0] {
    EXD_ST_IDLE = 2'h0,
    EXD_ST_EXEC = 2'h1
  } exd_state_e;
endpackage

// ### exd_datapath.sv
// Accumulator datapath: exchange, digit exchange, XOR, swap, carry, divide
// Functional notes
// - Nibble swap exchanges accumulator halves; flags stay unchanged.
// - Exchange writes operand to accumulator and accumulator to operand.
// - Exchange operand is working reg, direct byte, or indirect RAM.
// - Digit exchange swaps accumulator low nibble with indirect RAM nibble.
// - Digit exchange keeps both high nibbles and all flags.
// - XOR stores bitwise exclusive-or in destination; flags unchanged.
// - Accumulator-destination XOR takes reg, direct, indirect, immediate.
// - Direct-destination XOR takes accumulator or immediate as source.
// - XOR to a port reads the output latch, not the pins.
// - Opcode 01100101 is XOR accumulator with direct byte, two bytes.
// - Add/subtract with carry include the previous carry flag.
// - Carry flags unsigned over/underflow; overflow flag signed overflow.
// - Divide puts quotient in accumulator, remainder in B register.
`timescale 1ns/1ps
`include "exd_defines.svh"
module exd_datapath (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Instruction issue: one-cycle strobe with opcode and operand bytes
  input  wire logic       i_issue,
  input  wire logic [7:0] i_opcode,
  input  wire logic [7:0] i_byte2,
  input  wire logic [7:0] i_byte3,
  // Operand values fetched by the core
  input  wire logic [7:0] i_working_reg,
  input  wire logic [7:0] i_direct_val,
  input  wire logic       i_direct_is_port,
  input  wire logic [7:0] i_port_latch,
  input  wire logic [7:0] i_indirect_val,
  // Core-side write of the B register
  input  wire logic       i_b_load,
  input  wire logic [7:0] i_b_val,
  // State
  output logic      [7:0] o_acc,
  output logic      [7:0] o_b,
  output logic            o_carry,
  output logic            o_aux_carry,
  output logic            o_signed_overflow_flag,
  // Write-back
  output logic            o_wr_en,
  output logic      [1:0] o_wr_sel,
  output logic      [2:0] o_wr_reg_idx,
  output logic            o_wr_ptr_idx,
  output logic      [7:0] o_wr_addr,
  output logic      [7:0] o_wr_data,
  output logic      [1:0] o_length,
  output logic            o_illegal
);
  logic [7:0] acc_q, acc_d, b_q, b_d, wdat_q, wdat_d, wadr_q, wadr_d;
  logic       cy_q, cy_d, ac_q, ac_d, sov_q, sov_d, we_q, we_d, ill_q, ill_d;
  logic [1:0] wsel_q, wsel_d, len_q, len_d;
  logic [2:0] ridx_q, ridx_d;
  logic       pidx_q, pidx_d;
  logic [7:0] src, dst_old, sub_src;
  logic [8:0] sum;
  logic [4:0] lo;
  logic       add_op, sub_op, is_dir;
  exd_pkg::exd_src_e sel;

  always_comb begin
    acc_d  = acc_q;
    b_d    = b_q;
    cy_d   = cy_q;
    ac_d   = ac_q;
    sov_d  = sov_q;
    we_d   = 1'b0;
    wsel_d = wsel_q;
    wdat_d = wdat_q;
    wadr_d = wadr_q;
    len_d  = len_q;
    ill_d  = 1'b0;
    ridx_d = i_opcode[2:0];
    pidx_d = i_opcode[0];
    add_op = 1'b0;
    sub_op = 1'b0;
    is_dir = 1'b0;
    sum    = 9'h000;
    lo     = 5'h00;
    sub_src = 8'h00;
    // Operand class from low opcode bits, used by exchange, accumulator-destination XOR, add and subtract
    if (i_opcode[3]) sel = exd_pkg::EXD_SEL_REG;
    else if (i_opcode[2:1] == 2'h3) sel = exd_pkg::EXD_SEL_IND;
    else if (i_opcode[0]) sel = exd_pkg::EXD_SEL_DIR;
    else sel = exd_pkg::EXD_SEL_IMM;
    unique case (sel)
      exd_pkg::EXD_SEL_REG: src = i_working_reg;
      exd_pkg::EXD_SEL_DIR: src = i_direct_val;
      exd_pkg::EXD_SEL_IND: src = i_indirect_val;
      exd_pkg::EXD_SEL_IMM: src = i_byte2;
    endcase
    // Ports supply their output latch for read-modify-write
    dst_old = i_direct_is_port ? i_port_latch : i_direct_val;
    // Core writes B here; a divide result below takes priority
    if (i_b_load) begin
      b_d = i_b_val;
    end
    if (i_issue) begin
      len_d = 2'h1;
      if (i_opcode == `EXD_OP_SWAP) begin
        acc_d = {acc_q[3:0], acc_q[7:4]};
      end else if (i_opcode == `EXD_OP_EXCH_DIR ||
                   i_opcode[7:1] == `EXD_OP_EXCH_IND ||
                   i_opcode[7:3] == `EXD_OP_EXCH_REG) begin
        acc_d  = src;
        we_d   = 1'b1;
        wsel_d = sel;
        wdat_d = acc_q;
        wadr_d = i_byte2;
        len_d  = (sel == exd_pkg::EXD_SEL_DIR) ? 2'h2 : 2'h1;
      end else if (i_opcode[7:1] == `EXD_OP_DIGX_IND) begin
        acc_d  = {acc_q[7:4], i_indirect_val[3:0]};
        we_d   = 1'b1;
        wsel_d = exd_pkg::EXD_SEL_IND;
        wdat_d = {i_indirect_val[7:4], acc_q[3:0]};
      end else if (i_opcode[7:3] == `EXD_OP_XOR_REG ||
                   i_opcode == `EXD_OP_XOR_DIR ||
                   i_opcode[7:1] == `EXD_OP_XOR_IND ||
                   i_opcode == `EXD_OP_XOR_IMM) begin
        acc_d = acc_q ^ src;
        len_d = (i_opcode == `EXD_OP_XOR_DIR ||
                 i_opcode == `EXD_OP_XOR_IMM) ? 2'h2 : 2'h1;
      end else if (i_opcode == `EXD_OP_XOR_DA) begin
        we_d   = 1'b1;
        wsel_d = exd_pkg::EXD_SEL_DIR;
        wadr_d = i_byte2;
        wdat_d = dst_old ^ acc_q;
        len_d  = 2'h2;
      end else if (i_opcode == `EXD_OP_XOR_DI) begin
        we_d   = 1'b1;
        wsel_d = exd_pkg::EXD_SEL_DIR;
        wadr_d = i_byte2;
        wdat_d = dst_old ^ i_byte3;
        len_d  = 2'h3;
      end else if (i_opcode == `EXD_OP_DIV) begin
        if (b_q == 8'h00) begin
          sov_d = 1'b1;
        end else begin
          acc_d = acc_q / b_q;
          b_d   = acc_q % b_q;
          sov_d = 1'b0;
        end
        cy_d = 1'b0;
      end else begin
        add_op = i_opcode[7:3] == `EXD_OP_ADC_REG ||
                 i_opcode == `EXD_OP_ADC_DIR ||
                 i_opcode[7:1] == `EXD_OP_ADC_IND ||
                 i_opcode == `EXD_OP_ADC_IMM;
        sub_op = i_opcode[7:3] == `EXD_OP_SBB_REG ||
                 i_opcode == `EXD_OP_SBB_DIR ||
                 i_opcode[7:1] == `EXD_OP_SBB_IND ||
                 i_opcode == `EXD_OP_SBB_IMM;
        is_dir = (sel == exd_pkg::EXD_SEL_DIR) ||
                 (sel == exd_pkg::EXD_SEL_IMM);
        if (add_op || sub_op) begin
          // Subtract as add of complement with inverted carry
          sub_src = sub_op ? ~src : src;
          sum = {1'b0, acc_q} + {1'b0, sub_src}
              + {8'h00, cy_q ^ sub_op};
          lo  = {1'b0, acc_q[3:0]} + {1'b0, sub_src[3:0]}
              + {4'h0, cy_q ^ sub_op};
          acc_d = sum[7:0];
          cy_d  = sum[8] ^ sub_op;
          ac_d  = lo[4] ^ sub_op;
          sov_d = (acc_q[7] == sub_src[7]) &&
                  (sum[7] != acc_q[7]);
          len_d = is_dir ? 2'h2 : 2'h1;
        end else begin
          // Refused opcode sets the illegal flag and leaves accumulator, flags and length as they were
          ill_d = 1'b1;
          len_d = len_q;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_q  <= `EXD_ACC_RST;
      b_q    <= `EXD_B_RST;
      cy_q   <= 1'b0;
      ac_q   <= 1'b0;
      sov_q  <= 1'b0;
      we_q   <= 1'b0;
      wsel_q <= 2'h0;
      wdat_q <= 8'h00;
      wadr_q <= 8'h00;
      len_q  <= 2'h0;
      ill_q  <= 1'b0;
      ridx_q <= 3'h0;
      pidx_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      b_q    <= b_d;
      cy_q   <= cy_d;
      ac_q   <= ac_d;
      sov_q  <= sov_d;
      we_q   <= we_d;
      wsel_q <= wsel_d;
      wdat_q <= wdat_d;
      wadr_q <= wadr_d;
      len_q  <= len_d;
      ill_q  <= ill_d;
      ridx_q <= ridx_d;
      pidx_q <= pidx_d;
    end
  end

  assign o_acc                  = acc_q;
  assign o_b                    = b_q;
  assign o_carry                = cy_q;
  assign o_aux_carry            = ac_q;
  assign o_signed_overflow_flag = sov_q;
  assign o_wr_en                = we_q;
  assign o_wr_sel               = wsel_q;
  assign o_wr_reg_idx           = ridx_q;
  assign o_wr_ptr_idx           = pidx_q;
  assign o_wr_addr              = wadr_q;
  assign o_wr_data              = wdat_q;
  assign o_length               = len_q;
  assign o_illegal              = ill_q;

  a_swap_nibbles: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_issue && i_opcode == `EXD_OP_SWAP |=> o_acc == {$past(acc_q[3:0]),
    $past(acc_q[7:4])} && $stable(o_carry) && $stable(o_signed_overflow_flag))
    else $error("swap result wrong");
  a_exch_both: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_issue && i_opcode[7:3] == `EXD_OP_EXCH_REG |=> o_wr_en &&
    o_wr_data == $past(acc_q) && o_acc == $past(i_working_reg))
    else $error("exchange not symmetric");
  a_digx_high: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_issue && i_opcode[7:1] == `EXD_OP_DIGX_IND |=>
    o_acc[7:4] == $past(acc_q[7:4]) && o_wr_data[3:0] == $past(acc_q[3:0])
    && o_acc[3:0] == $past(i_indirect_val[3:0]) && $stable(o_carry))
    else $error("digit exchange wrong");
  a_xor_acc_dir: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_issue && i_opcode == `EXD_OP_XOR_DIR |=> o_length == 2'h2 &&
    o_acc == ($past(acc_q) ^ $past(i_direct_val)) && !o_wr_en)
    else $error("xor direct wrong");
  a_xor_port_latch: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_issue && i_opcode == `EXD_OP_XOR_DI && i_direct_is_port |=>
    o_wr_data == ($past(i_port_latch) ^ $past(i_byte3)) && o_length == 2'h3)
    else $error("port xor not from latch");
  a_xor_reg_idx: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_issue && i_opcode[7:3] == `EXD_OP_XOR_REG |=>
    o_acc == ($past(acc_q) ^ $past(i_working_reg)) && $stable(o_carry))
    else $error("xor register wrong");
  a_adc_chain: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_issue && i_opcode == `EXD_OP_ADC_IMM |=> {o_carry, o_acc} ==
    {1'b0, $past(acc_q)} + {1'b0, $past(i_byte2)} + {8'h00, $past(cy_q)})
    else $error("add with carry wrong");
  a_sbb_chain: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_issue && i_opcode == `EXD_OP_SBB_IMM |=> {o_carry, o_acc} ==
    {1'b0, $past(acc_q)} - {1'b0, $past(i_byte2)} - {8'h00, $past(cy_q)})
    else $error("subtract with borrow wrong");
  a_div_nibbles: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_issue && i_opcode == `EXD_OP_DIV && b_q == `EXD_NIB_DIV |=>
    o_acc == {4'h0, $past(acc_q[7:4])} && o_b == {4'h0, $past(acc_q[3:0])})
    else $error("divide placement wrong");
  c_exch_ind: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_issue && i_opcode[7:1] == `EXD_OP_EXCH_IND);
  c_digx: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_issue && i_opcode[7:1] == `EXD_OP_DIGX_IND);
  c_xor_port: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_issue && i_opcode == `EXD_OP_XOR_DA && i_direct_is_port);
  c_sbb_sovf: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_issue && i_opcode == `EXD_OP_SBB_IMM ##1 o_signed_overflow_flag);
endmodule // exd_datapath

// ### exd_datapath_tb_top.sv
// Self-checking testbench for the accumulator exchange / XOR datapath
`timescale 1ns/1ps
module exd_datapath_tb_top;
  logic       i_clk;
  logic       i_rst_n;
  logic       i_issue;
  logic [7:0] i_opcode;
  logic [7:0] i_byte2;
  logic [7:0] i_byte3;
  logic [7:0] i_working_reg;
  logic [7:0] i_direct_val;
  logic       i_direct_is_port;
  logic [7:0] i_port_latch;
  logic [7:0] i_indirect_val;
  logic       i_b_load;
  logic [7:0] i_b_val;
  logic [7:0] o_acc;
  logic [7:0] o_b;
  logic       o_carry;
  logic       o_aux_carry;
  logic       o_signed_overflow_flag;
  logic       o_wr_en;
  logic [1:0] o_wr_sel;
  logic [2:0] o_wr_reg_idx;
  logic       o_wr_ptr_idx;
  logic [7:0] o_wr_addr;
  logic [7:0] o_wr_data;
  logic [1:0] o_length;
  logic       o_illegal;
  int         fail_count;
  int         num_checks;

  `define CHK(nm, exp, got) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end

  exd_datapath dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_issue(i_issue),
    .i_opcode(i_opcode), .i_byte2(i_byte2), .i_byte3(i_byte3),
    .i_working_reg(i_working_reg), .i_direct_val(i_direct_val),
    .i_direct_is_port(i_direct_is_port), .i_port_latch(i_port_latch),
    .i_indirect_val(i_indirect_val), .i_b_load(i_b_load),
    .i_b_val(i_b_val), .o_acc(o_acc), .o_b(o_b),
    .o_carry(o_carry), .o_aux_carry(o_aux_carry),
    .o_signed_overflow_flag(o_signed_overflow_flag), .o_wr_en(o_wr_en),
    .o_wr_sel(o_wr_sel), .o_wr_reg_idx(o_wr_reg_idx),
    .o_wr_ptr_idx(o_wr_ptr_idx), .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data), .o_length(o_length), .o_illegal(o_illegal)
  );

  always #2 i_clk = ~i_clk;

  // One value feeds the register, direct and indirect sources; the opcode picks which one counts
  task automatic exec(input logic [7:0] op, input logic [7:0] b2,
                      input logic [7:0] v, input logic [7:0] b3 = 8'h00,
                      input logic port = 1'b0,
                      input logic [7:0] latch = 8'h00);
    @(posedge i_clk);
    i_issue          <= 1'b1;
    i_opcode         <= op;
    i_byte2          <= b2;
    i_byte3          <= b3;
    i_working_reg    <= v;
    i_direct_val     <= v;
    i_indirect_val   <= v;
    i_direct_is_port <= port;
    i_port_latch     <= latch;
    @(posedge i_clk);
    i_issue <= 1'b0;
    #1;
  endtask

  // Core-side write of B, used to set up a divide
  task automatic load_b(input logic [7:0] v);
    @(posedge i_clk);
    i_b_load <= 1'b1;
    i_b_val  <= v;
    @(posedge i_clk);
    i_b_load <= 1'b0;
    #1;
  endtask

  task automatic t_arith();
    exec(8'hC8, 8'h00, 8'hFF);
    exec(8'h34, 8'h01, 8'h00);
    `CHK("adc acc", 8'h00, o_acc)
    `CHK("adc carry", 1'b1, o_carry)
    `CHK("adc sovf", 1'b0, o_signed_overflow_flag)
    `CHK("adc aux", 1'b1, o_aux_carry)
    exec(8'hC9, 8'h00, 8'hC9);
    `CHK("exch keeps carry", 1'b1, o_carry)
    exec(8'h9A, 8'h00, 8'h54);
    `CHK("sbb acc", 8'h74, o_acc)
    `CHK("sbb carry", 1'b0, o_carry)
    `CHK("sbb sovf", 1'b1, o_signed_overflow_flag)
    `CHK("sbb aux", 1'b0, o_aux_carry)
  endtask

  task automatic t_xch();
    exec(8'hCB, 8'h00, 8'h3F);
    `CHK("exch reg acc", 8'h3F, o_acc)
    `CHK("exch reg data", 8'h74, o_wr_data)
    `CHK("exch reg en", 1'b1, o_wr_en)
    `CHK("exch reg sel", 2'h0, o_wr_sel)
    `CHK("exch reg idx", 3'h3, o_wr_reg_idx)
    exec(8'hC7, 8'h00, 8'h75);
    `CHK("exch ind acc", 8'h75, o_acc)
    `CHK("exch ind data", 8'h3F, o_wr_data)
    `CHK("exch ind sel", 2'h3, o_wr_sel)
    `CHK("exch ind ptr", 1'b1, o_wr_ptr_idx)
    exec(8'hC5, 8'h30, 8'hA5);
    `CHK("exch dir acc", 8'hA5, o_acc)
    `CHK("exch dir data", 8'h75, o_wr_data)
    `CHK("exch dir addr", 8'h30, o_wr_addr)
    `CHK("exch dir len", 2'h2, o_length)
  endtask

  task automatic t_digit();
    exec(8'hC9, 8'h00, 8'h36);
    exec(8'hD6, 8'h00, 8'h75);
    `CHK("digx acc", 8'h35, o_acc)
    `CHK("digx ram", 8'h76, o_wr_data)
    `CHK("digx sel", 2'h3, o_wr_sel)
    `CHK("digx sovf", 1'b1, o_signed_overflow_flag)
    exec(8'hC4, 8'h00, 8'h00);
    `CHK("swap acc", 8'h53, o_acc)
    `CHK("swap sovf", 1'b1, o_signed_overflow_flag)
    `CHK("swap len", 2'h1, o_length)
  endtask

  task automatic t_xor();
    exec(8'hC8, 8'h00, 8'hC3);
    exec(8'h6A, 8'h00, 8'hAA);
    `CHK("xor reg", 8'h69, o_acc)
    exec(8'h65, 8'h40, 8'h0F);
    `CHK("xor dir", 8'h66, o_acc)
    `CHK("xor dir len", 2'h2, o_length)
    exec(8'h67, 8'h00, 8'hFF);
    `CHK("xor ind", 8'h99, o_acc)
    exec(8'h64, 8'h11, 8'h00);
    `CHK("xor imm", 8'h88, o_acc)
    `CHK("xor sovf", 1'b1, o_signed_overflow_flag)
    exec(8'h62, 8'h50, 8'hF0);
    `CHK("xor da data", 8'h78, o_wr_data)
    `CHK("xor da addr", 8'h50, o_wr_addr)
    `CHK("xor da acc", 8'h88, o_acc)
    // Pins read FF, latch holds 34: only the latch may feed the result
    exec(8'h63, 8'h90, 8'hFF, 8'h31, 1'b1, 8'h34);
    `CHK("xor port data", 8'h05, o_wr_data)
    `CHK("xor port sel", 2'h1, o_wr_sel)
    `CHK("xor port len", 2'h3, o_length)
  endtask

  task automatic t_div_illegal();
    exec(8'hA5, 8'h00, 8'h00);
    `CHK("illegal flag", 1'b1, o_illegal)
    `CHK("illegal acc", 8'h88, o_acc)
    `CHK("illegal len", 2'h3, o_length)
    exec(8'h84, 8'h00, 8'h00);
    `CHK("div zero acc", 8'h88, o_acc)
    `CHK("div zero b", 8'h00, o_b)
    `CHK("div zero sovf", 1'b1, o_signed_overflow_flag)
    load_b(8'h10);
    `CHK("b load", 8'h10, o_b)
    exec(8'hC8, 8'h00, 8'h93);
    exec(8'h84, 8'h00, 8'h00);
    `CHK("div16 quotient", 8'h09, o_acc)
    `CHK("div16 remainder", 8'h03, o_b)
    `CHK("div16 sovf", 1'b0, o_signed_overflow_flag)
    `CHK("div16 carry", 1'b0, o_carry)
  endtask

  // Multi-byte chaining across add direct, indirect, register and subtract immediate, direct, indirect modes
  task automatic t_chain();
    exec(8'hC8, 8'h00, 8'h74);
    exec(8'h94, 8'h80, 8'h00);
    `CHK("sbb imm acc", 8'hF4, o_acc)
    `CHK("sbb imm carry", 1'b1, o_carry)
    `CHK("sbb imm sovf", 1'b1, o_signed_overflow_flag)
    exec(8'h35, 8'h20, 8'h0B);
    `CHK("adc dir acc", 8'h00, o_acc)
    `CHK("adc dir carry", 1'b1, o_carry)
    exec(8'h37, 8'h00, 8'h7F);
    `CHK("adc ind acc", 8'h80, o_acc)
    `CHK("adc ind carry", 1'b0, o_carry)
    `CHK("adc ind sovf", 1'b1, o_signed_overflow_flag)
    exec(8'h3A, 8'h00, 8'h01);
    `CHK("adc reg acc", 8'h81, o_acc)
    // Pins read FF, latch holds 34: the accumulator mask meets the latch
    exec(8'h62, 8'h50, 8'hFF, 8'h00, 1'b1, 8'h34);
    `CHK("xor da port data", 8'hB5, o_wr_data)
    exec(8'h95, 8'h00, 8'h01);
    `CHK("sbb dir acc", 8'h80, o_acc)
    exec(8'h97, 8'h00, 8'h80);
    `CHK("sbb ind acc", 8'h00, o_acc)
    `CHK("sbb ind carry", 1'b0, o_carry)
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #8000;
    fail_count++;
    results();
  end

  initial begin
    i_clk            = 1'b0;
    i_rst_n          = 1'b0;
    i_issue          = 1'b0;
    i_opcode         = 8'h00;
    i_byte2          = 8'h00;
    i_byte3          = 8'h00;
    i_working_reg    = 8'h00;
    i_direct_val     = 8'h00;
    i_direct_is_port = 1'b0;
    i_port_latch     = 8'h00;
    i_indirect_val   = 8'h00;
    i_b_load         = 1'b0;
    i_b_val          = 8'h00;
    fail_count       = 0;
    num_checks       = 0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_arith();
    t_xch();
    t_digit();
    t_xor();
    t_div_illegal();
    t_chain();
    results();
  end
endmodule // exd_datapath_tb_top
